// ==== logic/tseg_map.svh ====
/*
  Register offsets, field positions, masks and reset values of the timer
  event trigger block.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef TSEG_MAP_SVH
`define TSEG_MAP_SVH

// Register offsets on the register port.
`define TSEG_ADDR_W        8
`define TSEG_OFF_IEN       8'h0C
`define TSEG_OFF_STS       8'h10
`define TSEG_OFF_TRIG      8'h14
`define TSEG_OFF_CAPT      8'h34
`define TSEG_OFF_CLR       8'h44

// Register data width.
`define TSEG_DATA_W        16
`define TSEG_CNT_MAX_W     16

// Bit positions shared by the trigger, enable and status layouts.
`define TSEG_BIT_UPD       0
`define TSEG_BIT_CH1       1
`define TSEG_BIT_CTL       5
`define TSEG_BIT_BRK       7
`define TSEG_BIT_UPD_DMA   8
`define TSEG_BIT_CH1_DMA   9
`define TSEG_BIT_REPEAT    9

// Writable and readable bits of the enable and status registers, and the flags that drive the interrupt.
`define TSEG_IEN_MASK      16'h03A3
`define TSEG_STS_MASK      16'h02A3
`define TSEG_IRQ_MASK      16'h00A3

// Reset values.
`define TSEG_IEN_RST       16'h0000
`define TSEG_STS_RST       16'h0000
`define TSEG_ZERO16        16'h0000

`endif

// ==== logic/tseg_pkg.sv ====
/*
  Types of the timer event trigger block: counting modes, the command
  bundle to the counter datapath and the complete state of the block.
  Assumes the map header is on the include path.
*/
`include "tseg_map.svh"

package tseg_pkg;

  // Counting direction of the counter datapath.
  typedef enum logic [1:0] {
    TSEG_MODE_UP,
    TSEG_MODE_DOWN,
    TSEG_MODE_CENTER
  } tseg_mode_t;

  // Commands issued to the counter and prescaler datapath.
  typedef struct packed {
    logic                         load;
    logic [`TSEG_CNT_MAX_W-1:0]   value;
    logic                         prescClear;
  } tseg_cnt_cmd_t;

  // Pending self-clearing trigger bits.
  typedef struct packed {
    logic upd;
    logic ch1;
    logic ctl;
    logic brk;
  } tseg_pend_t;

  // Whole state of the top module.
  typedef struct packed {
    tseg_pend_t                 pend;
    logic [`TSEG_DATA_W-1:0]    ien;
    logic [`TSEG_DATA_W-1:0]    sts;
    logic [`TSEG_CNT_MAX_W-1:0] capt;
    logic [`TSEG_CNT_MAX_W-1:0] loadVal;
    logic [`TSEG_DATA_W-1:0]    rdata;
  } tseg_state_t;

endpackage : tseg_pkg

// ==== logic/tseg_sync.sv ====
/*
  Three flip-flop pin synchroniser with agreement filter.
  Assumes an asynchronous pin input and the block clock and reset.
*/
`timescale 1ns/1ps

module tseg_sync
  import tseg_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic pinIn,
  output logic      levelOut
);

  logic stage1_q;
  logic stage2_q;
  logic stage3_q;
  logic level_q;

  // The first stage feeds only the second; the output follows once stages two and three agree.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
      stage3_q <= 1'b0;
      level_q  <= 1'b0;
    end
    else
    begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      if (stage2_q == stage3_q)
      begin
        level_q <= stage3_q;
      end
    end
  end

  assign levelOut = level_q;

endmodule : tseg_sync

// ==== logic/tseg_top.sv ====
/*
  Timer software event generation block: trigger register, enable and
  status registers, forced update, channel 1, control update and break
  events, channel 1 capture register and one level interrupt.
  Assumes a register master on the same clock, a counter datapath that
  obeys the load and prescaler clear commands, and a break pin that is
  asynchronous to the clock.
*/
// Added by the designer: the address-and-strobe port.
// Functional notes
// RQ1 - Update trigger reinitialises counter, raises update event.
// RQ2 - Update trigger bit self-clears after issuing.
// RQ3 - Update clears prescaler count, keeps division factor.
// RQ4 - Down counting loads auto-reload value.
// RQ5 - Up or center counting resets counter.
// RQ6 - Channel 1 trigger forces event, self-clears.
// RQ7 - Output mode: set flag, interrupt, DMA.
// RQ8 - Input mode: capture counter, set flag.
// RQ9 - Capture with flag set sets repeat flag.
// RQ10 - Control update trigger issues event, self-clears.
// RQ11 - Control update only on complementary channels.
// RQ12 - Break trigger acts like valid break input.
// RQ13 - Channel 1 enables at bits 1, 9.
// RQ14 - Control update sets sticky flag.
// RQ15 - Break flag clears only after break ends.
// RQ16 - Zero writes ignored; trigger reads zero.
`timescale 1ns/1ps
`include "tseg_map.svh"

module tseg_top
  import tseg_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic [`TSEG_ADDR_W-1:0]  regAddr,
  input  wire logic [`TSEG_DATA_W-1:0]  regWdata,
  input  wire logic                     regWr,
  input  wire logic                     regRd,
  output logic      [`TSEG_DATA_W-1:0]  regRdata,
  input  wire tseg_mode_t               countMode,
  input  wire logic [CNT_W-1:0]         autoReloadValue,
  input  wire logic [CNT_W-1:0]         counterValue,
  input  wire logic                     ch1IsInput,
  input  wire logic                     ch1Complementary,
  input  wire logic                     breakPin,
  output tseg_cnt_cmd_t                 cntCmd,
  output logic                          updateEvent,
  output logic                          updateDmaReq,
  output logic                          ch1Event,
  output logic                          ch1DmaReq,
  output logic                          controlUpdate,
  output logic                          breakEvent,
  output logic                          irq
);

  // Refuse counter widths that do not fit the register fields, while elaborating.
  if (CNT_W < 1 || CNT_W > `TSEG_CNT_MAX_W)
  begin : g_badWidth
    $error("tseg_top: CNT_W out of range");
  end

  tseg_state_t state_q;
  tseg_state_t state_d;

  logic                        breakLevel;
  logic                        wrTrig;
  logic                        wrIen;
  logic                        wrClr;
  logic                        rdCapt;
  logic [`TSEG_DATA_W-1:0]     setMask;
  logic [`TSEG_DATA_W-1:0]     clrMask;
  logic [`TSEG_CNT_MAX_W-1:0]  arrWide;
  logic [`TSEG_CNT_MAX_W-1:0]  cntWide;
  logic                        ctlEffective;

  // The break pin passes the synchroniser before any logic looks at it.
  tseg_sync u_break_sync (
    .clk      (clk),
    .nrst     (nrst),
    .pinIn    (breakPin),
    .levelOut (breakLevel)
  );

  // Address decode of the register port.
  assign wrTrig = regWr && (regAddr == `TSEG_OFF_TRIG);
  assign wrIen  = regWr && (regAddr == `TSEG_OFF_IEN);
  assign wrClr  = regWr && (regAddr == `TSEG_OFF_CLR);
  assign rdCapt = regRd && (regAddr == `TSEG_OFF_CAPT);

  // Counter values widened to the register field width.
  assign arrWide = `TSEG_CNT_MAX_W'(autoReloadValue);
  assign cntWide = `TSEG_CNT_MAX_W'(counterValue);

  // The control update only acts where the channel has complementary outputs.
  assign ctlEffective = state_q.pend.ctl && ch1Complementary; // RQ11

  // Flags that hardware raises this cycle.
  always_comb
  begin
    setMask = `TSEG_ZERO16;
    if (state_q.pend.upd)
    begin
      setMask[`TSEG_BIT_UPD] = 1'b1; // RQ1
    end
    if (state_q.pend.ch1)
    begin
      setMask[`TSEG_BIT_CH1] = 1'b1; // RQ7
      if (ch1IsInput && state_q.sts[`TSEG_BIT_CH1])
      begin
        setMask[`TSEG_BIT_REPEAT] = 1'b1; // RQ9
      end
    end
    if (ctlEffective)
    begin
      setMask[`TSEG_BIT_CTL] = 1'b1; // RQ14
    end
    if (state_q.pend.brk || breakLevel)
    begin
      setMask[`TSEG_BIT_BRK] = 1'b1; // RQ12
    end
  end

  // Flags that software or a capture read asks to clear.
  always_comb
  begin
    clrMask = `TSEG_ZERO16;
    if (wrClr)
    begin
      clrMask = regWdata & `TSEG_STS_MASK;
    end
    if (breakLevel)
    begin
      clrMask[`TSEG_BIT_BRK] = 1'b0; // RQ15
    end
    if (rdCapt)
    begin
      clrMask[`TSEG_BIT_CH1] = 1'b1;
    end
  end

  // Next state of the whole block.
  always_comb
  begin
    state_d = state_q;

    // Trigger bits are pending for exactly one cycle, then clear themselves.
    state_d.pend.upd = wrTrig && regWdata[`TSEG_BIT_UPD]; // RQ2
    state_d.pend.ch1 = wrTrig && regWdata[`TSEG_BIT_CH1]; // RQ6
    state_d.pend.ctl = wrTrig && regWdata[`TSEG_BIT_CTL]; // RQ10
    state_d.pend.brk = wrTrig && regWdata[`TSEG_BIT_BRK]; // RQ12

    // The reload value is chosen from the counting mode when the trigger is written.
    if (wrTrig && regWdata[`TSEG_BIT_UPD])
    begin
      if (countMode == TSEG_MODE_DOWN)
      begin
        state_d.loadVal = arrWide; // RQ4
      end
      else
      begin
        state_d.loadVal = `TSEG_ZERO16; // RQ5
      end
    end

    // Enable register, reserved bits held at zero.
    if (wrIen)
    begin
      state_d.ien = regWdata & `TSEG_IEN_MASK; // RQ13
    end

    // Sticky status: a set in the same cycle as a clear wins.
    state_d.sts = ((state_q.sts & ~clrMask) | setMask) & `TSEG_STS_MASK;

    // A forced channel event in input mode captures the counter.
    if (state_q.pend.ch1 && ch1IsInput)
    begin
      state_d.capt = cntWide; // RQ8
    end

    // Read data stands in the cycle after the read strobe only.
    state_d.rdata = `TSEG_ZERO16;
    if (regRd)
    begin
      case (regAddr)
        `TSEG_OFF_IEN:  state_d.rdata = state_q.ien;
        `TSEG_OFF_STS:  state_d.rdata = state_q.sts;
        `TSEG_OFF_CAPT: state_d.rdata = state_q.capt;
        `TSEG_OFF_TRIG: state_d.rdata = `TSEG_ZERO16; // RQ16
        default:        state_d.rdata = `TSEG_ZERO16;
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q.pend    <= '0;
      state_q.ien     <= `TSEG_IEN_RST;
      state_q.sts     <= `TSEG_STS_RST;
      state_q.capt    <= `TSEG_ZERO16;
      state_q.loadVal <= `TSEG_ZERO16;
      state_q.rdata   <= `TSEG_ZERO16;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Commands to the counter datapath; the division factor lives elsewhere and is untouched.
  assign cntCmd.load       = state_q.pend.upd; // RQ1
  assign cntCmd.value      = state_q.loadVal;
  assign cntCmd.prescClear = state_q.pend.upd; // RQ3

  // Event pulses, one cycle after the trigger write.
  assign updateEvent   = state_q.pend.upd;
  assign updateDmaReq  = state_q.pend.upd && state_q.ien[`TSEG_BIT_UPD_DMA];
  assign ch1Event      = state_q.pend.ch1; // RQ6
  assign ch1DmaReq     = state_q.pend.ch1 && state_q.ien[`TSEG_BIT_CH1_DMA]; // RQ13
  assign controlUpdate = ctlEffective; // RQ11
  assign breakEvent    = state_q.pend.brk; // RQ12

  // Level interrupt while any enabled flag except the repeat flag is set.
  assign irq = |(state_q.sts & state_q.ien & `TSEG_IRQ_MASK); // RQ7

  assign regRdata = state_q.rdata;

endmodule : tseg_top

// ==== bench/tseg_event_props.sv ====
/*
  Concurrent checks on the ports of the timer event trigger block.
  Assumes one clock, clk, and the active low reset nrst.
*/
`timescale 1ns/1ps
`include "tseg_map.svh"

module tseg_event_props
  import tseg_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire logic [`TSEG_ADDR_W-1:0] regAddr,
  input wire logic [`TSEG_DATA_W-1:0] regWdata,
  input wire logic                    regWr,
  input wire logic                    regRd,
  input wire logic [`TSEG_DATA_W-1:0] regRdata,
  input wire tseg_mode_t              countMode,
  input wire logic [CNT_W-1:0]        autoReloadValue,
  input wire logic                    ch1Complementary,
  input wire tseg_cnt_cmd_t           cntCmd,
  input wire logic                    updateEvent,
  input wire logic                    ch1Event,
  input wire logic                    controlUpdate,
  input wire logic                    breakEvent
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // A write to the trigger register.
  wire trigWr = regWr && regAddr == `TSEG_OFF_TRIG;

  // A trigger write with one chosen bit set.
  sequence s_trig(int b);
    trigWr && regWdata[b];
  endsequence

  // Each trigger bit gives its pulse in the following cycle, the control bit only on a complementary channel; no pulse without its bit.
  property p_upd;
    s_trig(0) |=> updateEvent && cntCmd.load && cntCmd.prescClear;
  endproperty
  property p_down;
    s_trig(0) ##0 countMode == TSEG_MODE_DOWN
      |=> cntCmd.value[CNT_W-1:0] == $past(autoReloadValue);
  endproperty
  property p_up;
    s_trig(0) ##0 countMode != TSEG_MODE_DOWN |=> cntCmd.value == '0;
  endproperty
  property p_updQuiet;
    !(trigWr && regWdata[0]) |=> !updateEvent;
  endproperty
  property p_ch1;
    s_trig(1) |=> ch1Event;
  endproperty
  property p_ch1Quiet;
    !(trigWr && regWdata[1]) |=> !ch1Event;
  endproperty
  property p_ctl;
    s_trig(5) |=> controlUpdate == ch1Complementary;
  endproperty
  property p_brk;
    s_trig(7) |=> breakEvent;
  endproperty
  property p_ctlQuiet;
    !(trigWr && regWdata[5]) |=> !controlUpdate;
  endproperty
  property p_brkQuiet;
    !(trigWr && regWdata[7]) |=> !breakEvent;
  endproperty
  property p_rdZero;
    regRd && regAddr == `TSEG_OFF_TRIG |=> regRdata == '0;
  endproperty

  a_upd: assert property (p_upd) else $error("update pulse missing");
  a_down: assert property (p_down) else $error("reload value not loaded");
  a_up: assert property (p_up) else $error("counter not cleared");
  a_updQuiet: assert property (p_updQuiet) else $error("stray update");
  a_ch1: assert property (p_ch1) else $error("channel pulse missing");
  a_ch1Quiet: assert property (p_ch1Quiet) else $error("stray channel");
  a_ctl: assert property (p_ctl) else $error("control update wrong");
  a_brk: assert property (p_brk) else $error("break pulse missing");
  a_ctlQuiet: assert property (p_ctlQuiet) else $error("stray control update");
  a_brkQuiet: assert property (p_brkQuiet) else $error("stray break");
  a_rdZero: assert property (p_rdZero) else $error("trigger read not zero");
endmodule : tseg_event_props

bind tseg_top tseg_event_props #(.CNT_W(CNT_W)) props (
  .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .countMode(countMode),
  .autoReloadValue(autoReloadValue), .ch1Complementary(ch1Complementary), .cntCmd(cntCmd),
  .updateEvent(updateEvent), .ch1Event(ch1Event), .controlUpdate(controlUpdate),
  .breakEvent(breakEvent));

// ==== bench/test_timer_software_event_generation.sv ====
/*
  Self-checking bench of the timer event trigger block.
  Assumes the package, map header and checker are compiled before it.
*/
`timescale 1ns/1ps

module test_timer_software_event_generation
  import tseg_pkg::*;
;
  logic          clk = 0, nrst = 0, regWr = 0, regRd = 0, ch1IsInput = 0;
  logic          ch1Complementary = 0, breakPin = 0;
  logic [7:0]    regAddr = '0;
  logic [15:0]   regWdata = '0, regRdata, autoReloadValue = 16'h1234, counterValue = 16'h0ABC;
  tseg_mode_t    countMode = TSEG_MODE_UP;
  tseg_cnt_cmd_t cntCmd;
  logic          updateEvent, updateDmaReq, ch1Event, ch1DmaReq, controlUpdate, breakEvent, irq;
  logic [22:0]   r;
  int            fails = 0, checkCount = 0, cycles = 0;
  // Row layout: trigger data, mode, complementary flag, pulses {upd, ch1, ctl, brk}.
  localparam logic [22:0] ROWS [10] = '{23'h00_0088, 23'h00_00A8, 23'h00_00C8, 23'h00_0104,
    23'h00_1012, 23'h00_1000, 23'h00_4001, 23'h00_0010, 23'h7F_AE10, 23'h00_51BF};

  tseg_top #(.CNT_W(16)) dut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .countMode(countMode),
    .autoReloadValue(autoReloadValue), .counterValue(counterValue), .ch1IsInput(ch1IsInput),
    .ch1Complementary(ch1Complementary), .breakPin(breakPin), .cntCmd(cntCmd),
    .updateEvent(updateEvent), .updateDmaReq(updateDmaReq), .ch1Event(ch1Event),
    .ch1DmaReq(ch1DmaReq), .controlUpdate(controlUpdate), .breakEvent(breakEvent), .irq(irq));

  // Clock of 25 ns period.
  always #12.5 clk = ~clk;

  // Cuts a hang short.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fails++;
      finish_test();
    end
  end

  // Compares one value and counts it.
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checkCount++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One write cycle; returns just after the edge that took it.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask : wr

  // One read cycle; the data stand in the cycle after it.
  task automatic rdc(input string name, input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(name, exp, regRdata);
  endtask : rdc

  // Prints the counts and the verdict.
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // Main sequence: reset, table of trigger writes, then the awkward cases.
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rdc("enable", 8'h0C, 16'h0000);
    rdc("status", 8'h10, 16'h0000);
    chk("irq", 16'h0000, {15'h0000, irq});
    for (int i = 0; i < 10; i++)
    begin
      r = ROWS[i];
      @(posedge clk);
      countMode <= tseg_mode_t'(r[6:5]);
      ch1Complementary <= r[4];
      wr(8'h14, r[22:7]);
      chk("pulses", {12'h000, r[3:0]},
          {12'h000, updateEvent, ch1Event, controlUpdate, breakEvent});
      chk("cmd", {14'h0000, r[3], r[3]}, {14'h0000, cntCmd.load, cntCmd.prescClear});
      if (r[3])
        chk("value", (r[6:5] == 2'h1) ? 16'h1234 : 16'h0000, cntCmd.value);
      @(posedge clk);
      #1;
      chk("after", 16'h0000, {12'h000, updateEvent, ch1Event, controlUpdate, breakEvent});
    end
    rdc("flags", 8'h10, 16'h00A3);
    wr(8'h44, 16'h02A3);
    wr(8'h0C, 16'h0302);
    wr(8'h14, 16'h0003);
    chk("dma", 16'h0003, {14'h0000, updateDmaReq, ch1DmaReq});
    rdc("status", 8'h10, 16'h0003);
    chk("irq on", 16'h0001, {15'h0000, irq});
    wr(8'h0C, 16'h0300);
    rdc("enable", 8'h0C, 16'h0300);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    wr(8'h0C, 16'h0002);
    wr(8'h44, 16'h0003);
    rdc("cleared", 8'h10, 16'h0000);
    chk("irq off", 16'h0000, {15'h0000, irq});
    @(posedge clk);
    ch1IsInput <= 1'b1;
    wr(8'h14, 16'h0002);
    rdc("capture", 8'h10, 16'h0002);
    @(posedge clk);
    counterValue <= 16'h0DEF;
    wr(8'h14, 16'h0002);
    rdc("repeat", 8'h10, 16'h0202);
    rdc("captured", 8'h34, 16'h0DEF);
    rdc("read clear", 8'h10, 16'h0200);
    rdc("unmapped", 8'h20, 16'h0000);
    rdc("trigger", 8'h14, 16'h0000);
    @(posedge clk);
    breakPin <= 1'b1;
    repeat (6) @(posedge clk);
    wr(8'h44, 16'h0080);
    rdc("break held", 8'h10, 16'h0280);
    @(posedge clk);
    breakPin <= 1'b0;
    repeat (6) @(posedge clk);
    wr(8'h44, 16'h0280);
    rdc("break gone", 8'h10, 16'h0000);
    // A reset in mid-run must clear flags, enables, capture and pulses.
    wr(8'h0C, 16'h0303);
    wr(8'h14, 16'h0003);
    @(posedge clk);
    #1;
    chk("irq set", 16'h0001, {15'h0000, irq});
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("reset pulses", 16'h0000, {12'h000, updateEvent, ch1Event, cntCmd.load, irq});
    rdc("reset enable", 8'h0C, 16'h0000);
    rdc("reset status", 8'h10, 16'h0000);
    rdc("reset capture", 8'h34, 16'h0000);
    wr(8'h14, 16'h0001);
    chk("pulse after reset", 16'h0001, {15'h0000, updateEvent});
    finish_test();
  end
endmodule : test_timer_software_event_generation
